// File: logic/mmss_slave.sv
// Modbus RTU serial slave: UART, request parser and answer generator.
// Assumes rx_i comes from an RS-485 receiver and tx_en_o keys the driver.
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ns
module mmss_slave
  import mmss_pkg::*;
#(
  parameter int GAP_CYC_P = mmss_pkg::GAP_CYC  // Frame-ending silence
) (
  input  wire logic        clk_sys_i,   // 125 MHz clock
  input  wire logic        rst_i,       // Asynchronous reset
  input  wire logic        rx_i,        // Serial receive pin
  output logic             tx_o,        // Serial transmit pin
  output logic             tx_en_o,     // Driver enable, high sending
  input  wire logic [4:0]  addr_i,      // Local word index
  input  wire logic [15:0] wdata_i,     // Local write data
  input  wire logic        we_i,        // Local write strobe
  input  wire logic        re_i,        // Local read strobe
  output logic      [15:0] rdata_o,     // Local read data
  input  wire logic        mem_err_i,   // Memory error detected
  input  wire logic        csum_err_i,  // Code checksum failed
  output logic             fault_mem_o, // Memory fault shown
  output logic             fault_csum_o,// Checksum fault shown
  output logic             cmd_pend_o   // Command awaits software
);
  import mmss_pkg::*;

  typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP} mmss_rx_e;
  typedef enum {T_IDLE, T_FETCH, T_LOAD, T_WAIT} mmss_tx_e;

  mmss_cfg_s   cfg_q, cfg_d;
  mmss_div_t   div;
  logic        par_on;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  assign div    = baud_div(cfg_q.baud);
  assign par_on = (cfg_q.parity != PAR_NONE);

  // ****************************************************************
  // Receiver
  // ****************************************************************
  logic [2:0]  sync_q;
  logic        rx_lvl_q, rx_lvl_d;
  mmss_rx_e    rx_st_q, rx_st_d;
  mmss_div_t   rx_cnt_q, rx_cnt_d;
  logic [3:0]  rx_bit_q, rx_bit_d;
  logic [8:0]  rx_sh_q, rx_sh_d;
  logic        rx_vld_q, rx_vld_d, rx_bad_q, rx_bad_d;
  logic [7:0]  rx_byte;
  logic        rx_perr;

  assign rx_byte = par_on ? rx_sh_q[7:0] : rx_sh_q[8:1];
  assign rx_perr = par_on && ((^rx_sh_q) != (cfg_q.parity == PAR_ODD));

  always_comb begin
    rx_lvl_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : rx_lvl_q;
    rx_st_d  = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d  = rx_sh_q;
    rx_vld_d = 1'b0;
    rx_bad_d = rx_bad_q;
    unique case (rx_st_q)
      RX_IDLE: if (!rx_lvl_q) begin
        rx_st_d  = RX_START;
        rx_cnt_d = div >> 1;
      end
      RX_START: if (rx_cnt_q == '0) begin
        rx_st_d  = rx_lvl_q ? RX_IDLE : RX_BITS;  // Ignore short glitches
        rx_cnt_d = div - 17'h1;
        rx_bit_d = DATA_BITS + {3'h0, par_on};
      end else begin
        rx_cnt_d = rx_cnt_q - 17'h1;
      end
      RX_BITS: if (rx_cnt_q == '0) begin
        rx_sh_d  = {rx_lvl_q, rx_sh_q[8:1]};
        rx_cnt_d = div - 17'h1;
        rx_bit_d = rx_bit_q - 4'h1;
        if (rx_bit_q == 4'h1) rx_st_d = RX_STOP;
      end else begin
        rx_cnt_d = rx_cnt_q - 17'h1;
      end
      RX_STOP: if (rx_cnt_q == '0) begin
        rx_vld_d = 1'b1;
        rx_bad_d = !rx_lvl_q || rx_perr;
        rx_st_d  = RX_IDLE;
      end else begin
        rx_cnt_d = rx_cnt_q - 17'h1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync_q   <= 3'h7;
      rx_lvl_q <= 1'b1;
      rx_st_q  <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 9'h000;
      rx_vld_q <= 1'b0;
      rx_bad_q <= 1'b0;
    end else begin
      sync_q   <= {sync_q[1:0], rx_i};
      rx_lvl_q <= rx_lvl_d;
      rx_st_q  <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q  <= rx_sh_d;
      rx_vld_q <= rx_vld_d;
      rx_bad_q <= rx_bad_d;
    end
  end

  // ****************************************************************
  // Request parser
  // ****************************************************************
  mmss_req_s        req_q, req_d;
  logic [3:0]       p_idx_q, p_idx_d;
  logic [15:0]      crc_q, crc_d;
  logic             p_ok_q, p_ok_d, go_q, go_d;
  logic [GAP_W-1:0] gap_q, gap_d;
  mmss_tx_e         tx_st_q, tx_st_d;

  always_comb begin
    req_d   = req_q;
    p_idx_d = p_idx_q;
    crc_d   = crc_q;
    p_ok_d  = p_ok_q;
    gap_d   = gap_q;
    go_d    = 1'b0;
    if (rx_vld_q) begin
      gap_d = '0;
      if (p_idx_q < REQ_BYTES) p_idx_d = p_idx_q + 4'h1;
      if (rx_bad_q) p_ok_d = 1'b0;
      if (p_idx_q < CRC_LO_IDX) begin
        req_d = mmss_req_s'({req_q[39:0], rx_byte});
        crc_d = crc_step(crc_q, rx_byte);
      end else if (p_idx_q == CRC_LO_IDX) begin
        p_ok_d = p_ok_d && (rx_byte == crc_q[7:0]);
      end else if (p_idx_q == CRC_HI_IDX) begin
        // Busy answering: the request is dropped, the master retries
        go_d = p_ok_d && (rx_byte == crc_q[15:8]) &&
               (req_q.station == cfg_q.station) &&
               (tx_st_q == T_IDLE);
      end
    end else if (gap_q == GAP_W'(GAP_CYC_P - 1)) begin
      p_idx_d = 4'h0;
      crc_d   = CRC_INIT;
      p_ok_d  = 1'b1;
    end else begin
      gap_d = gap_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      req_q   <= '0;
      p_idx_q <= 4'h0;
      crc_q   <= CRC_INIT;
      p_ok_q  <= 1'b1;
      gap_q   <= '0;
      go_q    <= 1'b0;
    end else begin
      req_q   <= req_d;
      p_idx_q <= p_idx_d;
      crc_q   <= crc_d;
      p_ok_q  <= p_ok_d;
      gap_q   <= gap_d;
      go_q    <= go_d;
    end
  end

  // ****************************************************************
  // Answer generator and transmitter
  // ****************************************************************
  mmss_req_s   rsp_q, rsp_d;
  logic [7:0]  ex_q, ex_d, tb;
  logic [4:0]  idx_q, idx_d, off, rsp_len;
  logic [15:0] tcrc_q, tcrc_d, word_a, wordv, mem_b;
  logic        en_q, en_d, cmd_wr_q, cmd_wr_d, ut_go, ut_done;
  logic        tx_q, tx_d;
  mmss_div_t   ut_cnt_q, ut_cnt_d;
  logic [3:0]  ut_left_q, ut_left_d;
  logic [9:0]  ut_sh_q, ut_sh_d;
  mmss_acc_e   acc_f, acc_l;

  assign acc_f   = access_of(req_q.addr);
  assign acc_l   = access_of(req_q.addr + req_q.val - 16'h1);
  assign off     = idx_q - 5'h3;
  assign word_a  = rsp_q.addr + {12'h000, off[4:1]};
  assign rsp_len = (ex_q != EX_NONE) ? 5'h3 :
                   (rsp_q.func == FC_READ) ? 5'h3 + {rsp_q.val[3:0], 1'b0}
                                           : 5'h6;
  assign ut_done = (ut_left_q == 4'h1) && (ut_cnt_q == '0);

  // Words leave as raw 16-bit images, so every data type keeps its
  // encoding and a wide value spans its registers untouched
  always_comb begin
    unique case (word_a)
      MB_STATION: wordv = {8'h00, cfg_q.station};
      MB_BAUD:    wordv = {13'h0000, cfg_q.baud};
      MB_PARITY:  wordv = {14'h0000, cfg_q.parity};
      default:    wordv = mem_b;
    endcase
    tb = 8'h00;
    if (idx_q == rsp_len) begin
      tb = tcrc_q[7:0];
    end else if (idx_q == rsp_len + 5'h1) begin
      tb = tcrc_q[15:8];
    end else if (idx_q == 5'h0) begin
      tb = rsp_q.station;
    end else if (idx_q == 5'h1) begin
      tb = rsp_q.func | ((ex_q != EX_NONE) ? EX_FLAG : 8'h00);
    end else if (ex_q != EX_NONE) begin
      tb = ex_q;
    end else if (rsp_q.func == FC_READ) begin
      if (idx_q == 5'h2) tb = {rsp_q.val[6:0], 1'b0};
      else tb = off[0] ? wordv[7:0] : wordv[15:8];
    end else begin
      unique case (idx_q)
        5'h2:    tb = rsp_q.addr[15:8];
        5'h3:    tb = rsp_q.addr[7:0];
        5'h4:    tb = rsp_q.val[15:8];
        default: tb = rsp_q.val[7:0];
      endcase
    end
  end

  always_comb begin
    tx_st_d  = tx_st_q;
    rsp_d    = rsp_q;
    ex_d     = ex_q;
    idx_d    = idx_q;
    tcrc_d   = tcrc_q;
    en_d     = en_q;
    cmd_wr_d = 1'b0;
    ut_go    = 1'b0;
    unique case (tx_st_q)
      T_IDLE: if (go_q) begin
        rsp_d   = req_q;
        idx_d   = 5'h0;
        tcrc_d  = CRC_INIT;
        en_d    = 1'b1;
        tx_st_d = T_FETCH;
        ex_d    = EX_NONE;
        if (req_q.func == FC_READ) begin
          if (req_q.val == 16'h0 || req_q.val > MAX_READ) begin
            ex_d = EX_VAL;
          end else if (acc_f inside {ACC_NONE, ACC_WO} ||
                       acc_l inside {ACC_NONE, ACC_WO}) begin
            ex_d = EX_ADDR;
          end
        end else if (req_q.func == FC_WRITE) begin
          if (acc_f != ACC_WO) ex_d = EX_ADDR;
          else cmd_wr_d = 1'b1;
        end else begin
          ex_d = EX_FUNC;
        end
      end
      T_FETCH: tx_st_d = T_LOAD;  // Memory word lands next cycle
      T_LOAD: begin
        if (idx_q < rsp_len) tcrc_d = crc_step(tcrc_q, tb);
        ut_go   = 1'b1;
        tx_st_d = T_WAIT;
      end
      T_WAIT: if (ut_done) begin
        if (idx_q == rsp_len + 5'h1) begin
          tx_st_d = T_IDLE;
          en_d    = 1'b0;
        end else begin
          idx_d   = idx_q + 5'h1;
          tx_st_d = T_FETCH;
        end
      end
    endcase
    tx_d      = tx_q;
    ut_cnt_d  = ut_cnt_q;
    ut_left_d = ut_left_q;
    ut_sh_d   = ut_sh_q;
    if (ut_go) begin
      tx_d      = 1'b0;
      ut_cnt_d  = div - 17'h1;
      ut_left_d = FRAME_PER + {3'h0, par_on};
      ut_sh_d   = par_on ? {1'b1, (cfg_q.parity == PAR_ODD) ^ (^tb), tb}
                         : {2'h3, tb};
    end else if (ut_left_q != 4'h0) begin
      if (ut_cnt_q == '0) begin
        tx_d      = ut_sh_q[0];
        ut_sh_d   = {1'b1, ut_sh_q[9:1]};
        ut_left_d = ut_left_q - 4'h1;
        ut_cnt_d  = div - 17'h1;
      end else begin
        ut_cnt_d = ut_cnt_q - 17'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_q   <= T_IDLE;
      rsp_q     <= '0;
      ex_q      <= EX_NONE;
      idx_q     <= 5'h0;
      tcrc_q    <= CRC_INIT;
      en_q      <= 1'b0;
      cmd_wr_q  <= 1'b0;
      tx_q      <= 1'b1;
      ut_cnt_q  <= '0;
      ut_left_q <= 4'h0;
      ut_sh_q   <= 10'h3ff;
    end else begin
      tx_st_q   <= tx_st_d;
      rsp_q     <= rsp_d;
      ex_q      <= ex_d;
      idx_q     <= idx_d;
      tcrc_q    <= tcrc_d;
      en_q      <= en_d;
      cmd_wr_q  <= cmd_wr_d;
      tx_q      <= tx_d;
      ut_cnt_q  <= ut_cnt_d;
      ut_left_q <= ut_left_d;
      ut_sh_q   <= ut_sh_d;
    end
  end

  // ****************************************************************
  // Local registers
  // ****************************************************************
  logic [15:0] cmd_q, cmd_d, alt;
  logic        pend_q, pend_d, fm_q, fm_d, fc_q, fc_d;

  always_comb begin
    cfg_d  = cfg_q;
    cmd_d  = cmd_q;
    pend_d = pend_q;
    fm_d   = fm_q | mem_err_i;
    fc_d   = fc_q | csum_err_i;
    if (we_i) begin
      unique case (addr_i)
        LA_STATION: if (wdata_i[15:8] == 8'h00 &&
                        wdata_i[7:0] >= STN_MIN &&
                        wdata_i[7:0] <= STN_MAX) begin
          cfg_d.station = wdata_i[7:0];
        end
        LA_BAUD: if (wdata_i <= {13'h0000, BAUD_MAX}) begin
          cfg_d.baud = wdata_i[2:0];
        end
        LA_PARITY: if (wdata_i <= {14'h0000, PAR_NONE}) begin
          cfg_d.parity = wdata_i[1:0];
        end
        LA_CMD:  pend_d = 1'b0;
        default: ;
      endcase
    end
    // A new command wins over a clear in the same cycle
    if (cmd_wr_q) begin
      cmd_d  = rsp_q.val;
      pend_d = 1'b1;
    end
    unique case (addr_i)
      LA_STATION: alt = {8'h00, cfg_q.station};
      LA_BAUD:    alt = {13'h0000, cfg_q.baud};
      LA_PARITY:  alt = {14'h0000, cfg_q.parity};
      LA_CMD:     alt = cmd_q;
      LA_STATUS:  alt = {13'h0000, fc_q, fm_q, pend_q};
      default:    alt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q  <= CFG_RST;
      cmd_q  <= 16'h0000;
      pend_q <= 1'b0;
      fm_q   <= 1'b0;
      fc_q   <= 1'b0;
    end else begin
      cfg_q  <= cfg_d;
      cmd_q  <= cmd_d;
      pend_q <= pend_d;
      fm_q   <= fm_d;
      fc_q   <= fc_d;
    end
  end

  mmss_mem u_mem (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .we_i      (we_i && addr_i[LA_MEM_BIT]),
    .wa_i      (addr_i[3:0]),
    .wd_i      (wdata_i),
    .re_a_i    (re_i),
    .ra_a_i    (addr_i[3:0]),
    .alt_a_i   (!addr_i[LA_MEM_BIT]),
    .alt_i     (alt),
    .rd_a_o    (rdata_o),
    .ra_b_i    (word_a[3:0]),
    .rd_b_o    (mem_b)
  );

  assign tx_o         = tx_q;
  assign tx_en_o      = en_q;
  assign fault_mem_o  = fm_q;
  assign fault_csum_o = fc_q;
  assign cmd_pend_o   = pend_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_load;
    ut_go;
  endsequence
  sequence s_start_bit;
    !tx_q && ut_left_q == FRAME_PER + {3'h0, par_on};
  endsequence

  rst_cfg_a: assert property ($past(rst_i) |-> cfg_q == CFG_RST)
    else $error("configuration not at defaults after reset");
  stn_range_a: assert property (
      cfg_q.station inside {[STN_MIN:STN_MAX]})
    else $error("station address out of range");
  baud_code_a: assert property (cfg_q.baud <= BAUD_MAX)
    else $error("illegal baud code held");
  par_code_a: assert property (cfg_q.parity != 2'h3)
    else $error("illegal parity code held");
  // Station as it stood when the request was accepted, not after a write
  own_stn_a: assert property (
      go_q |-> req_q.station == $past(cfg_q.station))
    else $error("answer started for another station");
  cfg_direct_a: assert property ($changed(cfg_q) |-> $past(we_i))
    else $error("configuration changed without local write");
  read_cnt_a: assert property (go_q && req_q.func == FC_READ &&
      (req_q.val == 16'h0 || req_q.val > MAX_READ) |=> ex_q == EX_VAL)
    else $error("bad register count not refused");
  wr_class_a: assert property (go_q && req_q.func == FC_WRITE &&
      acc_f != ACC_WO |=> ex_q == EX_ADDR ##1 (!pend_q || $past(pend_q)))
    else $error("write to non-writable register accepted");
  fault_hold_a: assert property ((mem_err_i |=> fm_q [*4]) and
      (csum_err_i |=> fc_q [*4]))
    else $error("fault indication not held");
  frame_fix_a: assert property (s_load |=> s_start_bit ##1 !tx_q [*3])
    else $error("character frame did not start as fixed");
endmodule

// File: logic/mmss_pkg.sv
// Constants, types and helpers shared by the Modbus serial slave files.
// Assumes one 125 MHz system clock and RTU framing on the serial line.
package mmss_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ  = 125_000_000;
  localparam int GAP_US  = 1750;          // Line silence ending a frame
  localparam int GAP_CYC = CLK_HZ / 1_000_000 * GAP_US;
  localparam int GAP_W   = 18;

  // ****************************************************************
  // Character framing and configuration codes
  // ****************************************************************
  localparam logic [3:0] DATA_BITS  = 4'h8;
  localparam logic [3:0] FRAME_PER  = 4'ha;   // Start, data, one stop
  localparam logic [2:0] BAUD_9600  = 3'h0;
  localparam logic [2:0] BAUD_19200 = 3'h1;
  localparam logic [2:0] BAUD_38400 = 3'h2;
  localparam logic [2:0] BAUD_4800  = 3'h3;
  localparam logic [2:0] BAUD_2400  = 3'h4;
  localparam logic [2:0] BAUD_1200  = 3'h5;
  localparam logic [2:0] BAUD_MAX   = BAUD_1200;
  localparam logic [1:0] PAR_EVEN   = 2'h0;
  localparam logic [1:0] PAR_ODD    = 2'h1;
  localparam logic [1:0] PAR_NONE   = 2'h2;
  localparam logic [7:0] STN_MIN    = 8'h01;
  localparam logic [7:0] STN_MAX    = 8'hf7;

  typedef struct packed {
    logic [7:0] station;
    logic [2:0] baud;
    logic [1:0] parity;
  } mmss_cfg_s;

  localparam mmss_cfg_s CFG_RST = '{station: 8'h01, baud: BAUD_19200,
                                    parity: PAR_EVEN};

  // ****************************************************************
  // Local register port map (word indices) and status bits
  // ****************************************************************
  localparam logic [4:0] LA_STATION = 5'h00;
  localparam logic [4:0] LA_BAUD    = 5'h01;
  localparam logic [4:0] LA_PARITY  = 5'h02;
  localparam logic [4:0] LA_CMD     = 5'h03;
  localparam logic [4:0] LA_STATUS  = 5'h04;
  localparam int         LA_MEM_BIT = 4;      // Upper half is data memory
  localparam int ST_CMD_PEND   = 0;
  localparam int ST_MEM_FAULT  = 1;
  localparam int ST_CSUM_FAULT = 2;

  // ****************************************************************
  // Modbus side map, functions and exceptions
  // ****************************************************************
  localparam logic [15:0] MB_DATA_END = 16'h000f;
  localparam logic [15:0] MB_CMD      = 16'h1482;
  localparam logic [15:0] MB_STATION  = 16'h1965;
  localparam logic [15:0] MB_BAUD     = 16'h1966;
  localparam logic [15:0] MB_PARITY   = 16'h1967;
  localparam logic [15:0] MAX_READ    = 16'h0008;
  localparam logic [7:0]  FC_READ     = 8'h03;
  localparam logic [7:0]  FC_WRITE    = 8'h06;
  localparam logic [7:0]  EX_FLAG     = 8'h80;
  localparam logic [7:0]  EX_NONE     = 8'h00;
  localparam logic [7:0]  EX_FUNC     = 8'h01;
  localparam logic [7:0]  EX_ADDR     = 8'h02;
  localparam logic [7:0]  EX_VAL      = 8'h03;
  localparam logic [3:0]  CRC_LO_IDX  = 4'h6;
  localparam logic [3:0]  CRC_HI_IDX  = 4'h7;
  localparam logic [3:0]  REQ_BYTES   = 4'h8;
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'ha001;

  typedef logic [16:0] mmss_div_t;
  typedef enum logic [1:0] {ACC_NONE, ACC_RO, ACC_WO, ACC_VIA_CMD} mmss_acc_e;

  typedef struct packed {
    logic [7:0]  station;
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] val;
  } mmss_req_s;

  function automatic mmss_div_t baud_div(input logic [2:0] code);
    unique case (code)
      BAUD_9600:  return mmss_div_t'(CLK_HZ / 9600);
      BAUD_38400: return mmss_div_t'(CLK_HZ / 38400);
      BAUD_4800:  return mmss_div_t'(CLK_HZ / 4800);
      BAUD_2400:  return mmss_div_t'(CLK_HZ / 2400);
      BAUD_1200:  return mmss_div_t'(CLK_HZ / 1200);
      default:    return mmss_div_t'(CLK_HZ / 19200);
    endcase
  endfunction

  function automatic mmss_acc_e access_of(input logic [15:0] a);
    if (a <= MB_DATA_END) return ACC_RO;
    if (a == MB_CMD) return ACC_WO;
    if (a >= MB_STATION && a <= MB_PARITY) return ACC_VIA_CMD;
    return ACC_NONE;
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// File: logic/mmss_mem.sv
// Sixteen-word data memory of the Modbus serial slave.
// Assumes one writer; both read ports return data from a register.
`timescale 1ns/1ns
module mmss_mem (
  input  wire logic        clk_sys_i,  // System clock
  input  wire logic        rst_i,      // Asynchronous reset
  input  wire logic        we_i,       // Write strobe
  input  wire logic [3:0]  wa_i,       // Write word index
  input  wire logic [15:0] wd_i,       // Write data
  input  wire logic        re_a_i,     // Port A read strobe
  input  wire logic [3:0]  ra_a_i,     // Port A word index
  input  wire logic        alt_a_i,    // Port A takes alt_i instead
  input  wire logic [15:0] alt_i,      // Port A bypass word
  output logic      [15:0] rd_a_o,     // Port A read data
  input  wire logic [3:0]  ra_b_i,     // Port B word index
  output logic      [15:0] rd_b_o      // Port B read data
);
  logic [15:0] mem_q [16];

  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem_q[wa_i] <= wd_i;
    end
  end

  // Bypass lets the top return register words from this same flop
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_a_o <= 16'h0000;
      rd_b_o <= 16'h0000;
    end else begin
      if (re_a_i) begin
        rd_a_o <= alt_a_i ? alt_i : mem_q[ra_a_i];
      end
      rd_b_o <= mem_q[ra_b_i];
    end
  end
endmodule

// File: sim/mmss_master.sv
// Serial master model that drives the receive pin of the slave.
// Assumes the bench sets bit period and parity to match the slave.
`timescale 1ns/1ns
module mmss_master #(
  parameter int DIV_P = 3255,  // Cycles per bit
  parameter int PAR_P = 0      // 0 even, 1 odd, 2 none
) (
  input  wire logic clk_sys_i,  // System clock
  output logic      line_o      // Slave receive pin
);
  // ****************************************************************
  // Character sender
  // ****************************************************************
  initial line_o = 1'b1;
  // Fields go out unchanged; register number is already less one
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] f;
    // Without parity the spare slot is a second idle-high bit
    f = (PAR_P == 2) ? {2'b11, b, 1'b0}
                     : {1'b1, (PAR_P == 1) ^ (^b), b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_sys_i);
      line_o <= f[i];
      repeat (DIV_P - 1) @(posedge clk_sys_i);
    end
  endtask
endmodule

// File: sim/tb.sv
// Self-checking bench for the Modbus serial slave, local port first.
// Assumes a full frame is too long to simulate; one character is sent.
`timescale 1ns/1ns
`define CHK(g, e) chk(16'(g), 16'(e));
module tb;
  import mmss_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic        clk_sys_i, rst_i, rx_i, we_i, re_i, mem_err_i, csum_err_i;
  logic [4:0]  addr_i;
  logic [15:0] wdata_i, rdata_o;
  logic        tx_o, tx_en_o, fault_mem_o, fault_csum_o, cmd_pend_o;
  logic        saw_tx;
  int          err_total, n_checks;
  mmss_slave #(.GAP_CYC_P(40000)) mmss_slave_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rx_i(rx_i), .tx_o(tx_o),
    .tx_en_o(tx_en_o), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .mem_err_i(mem_err_i),
    .csum_err_i(csum_err_i), .fault_mem_o(fault_mem_o),
    .fault_csum_o(fault_csum_o), .cmd_pend_o(cmd_pend_o));
  mmss_master #(.DIV_P(3255), .PAR_P(0)) mmss_master_inst (
    .clk_sys_i(clk_sys_i), .line_o(rx_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    saw_tx <= !rst_i && (saw_tx || tx_en_o === 1'b1);
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_sys_i);
    re_i <= 1'b0;
    #1 `CHK(rdata_o, e)
  endtask
  task automatic wrchk(input logic [4:0] a, input logic [15:0] v,
                       input logic [15:0] e);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= v;
    we_i    <= 1'b1;
    @(posedge clk_sys_i);
    we_i <= 1'b0;
    rdchk(a, e);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    err_total++;
    report_and_stop();
  end
  initial begin
    {we_i, re_i, mem_err_i, csum_err_i} = '0;
    addr_i = '0;
    wdata_i = '0;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    `CHK(tx_o, 1)
    rdchk(LA_STATION, 16'h0001);
    rdchk(LA_BAUD, 16'(BAUD_19200));
    rdchk(LA_PARITY, 16'(PAR_EVEN));
    wrchk(LA_STATION, 16'h0000, 16'h0001);
    wrchk(LA_STATION, 16'h00f8, 16'h0001);
    wrchk(LA_STATION, 16'h01f7, 16'h0001);
    wrchk(LA_STATION, 16'(STN_MAX), 16'(STN_MAX));
    for (int c = 0; c < 8; c++) begin
      wrchk(LA_BAUD, 16'(c), 16'(c > 5 ? 5 : c));
    end
    for (int c = 0; c < 4; c++) begin
      wrchk(LA_PARITY, 16'(c), 16'(c > 2 ? 2 : c));
    end
    wrchk(LA_PARITY, 16'(PAR_EVEN), 16'(PAR_EVEN));
    wrchk(LA_BAUD, 16'(BAUD_38400), 16'(BAUD_38400));
    wrchk(LA_STATUS, 16'hffff, 16'h0000);
    wrchk(5'h05, 16'hffff, 16'h0000);
    wrchk(5'h10, 16'hffff, 16'hffff);
    wrchk(LA_CMD, 16'h0001, 16'h0000);
    `CHK(cmd_pend_o, 0)
    @(posedge clk_sys_i);
    mem_err_i <= 1'b1;
    @(posedge clk_sys_i);
    mem_err_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    `CHK({fault_mem_o, fault_csum_o}, 2'b10)
    csum_err_i <= 1'b1;
    @(posedge clk_sys_i);
    csum_err_i <= 1'b0;
    rdchk(LA_STATUS, 16'h0006);
    `CHK({fault_mem_o, fault_csum_o}, 2'b11)
    // A character for another station must leave the driver off
    mmss_master_inst.send_byte(8'h02);
    repeat (1000) @(posedge clk_sys_i);
    `CHK({saw_tx, tx_o}, 2'b01)
    // The character must have been taken as 8E1 at the selected rate
    `CHK(mmss_slave_inst.req_q[7:0], 8'h02)
    `CHK(mmss_slave_inst.p_ok_q, 1)
    report_and_stop();
  end
endmodule
